// File: verilog/spov_defs.svh
// Purpose: constants for the serial port overflow and enable block
// Assumes: one 100 MHz clock, byte-wide transfers
// Notes: bit positions follow the control register layout
`ifndef SPOV_DEFS_SVH
`define SPOV_DEFS_SVH
`define SPOV_OVF_BIT 6
`define SPOV_EN_BIT 5
`define SPOV_BYTE_W 8
`define SPOV_FIFO_DEPTH 16
`define SPOV_FIFO_AW 4
`define SPOV_BUF_RESET 8'h00
`endif

// File: verilog/spov_pkg.sv
// Purpose: types for the serial port overflow and enable block
// Assumes: constants come from spov_defs.svh
// Notes: modes and pin groups travel as packed types
`include "spov_defs.svh"
package spov_pkg;
  typedef enum logic {spov_mode_spi, spov_mode_i2c} spov_mode_t;
  // pin triple: input, output, output enable
  typedef struct packed
  {
    logic in;
    logic out;
    logic oe;
  } spov_pin_t;
  // general-purpose side of a pin
  typedef struct packed
  {
    logic out;
    logic oe;
  } spov_gpio_t;
endpackage : spov_pkg

// File: verilog/spov_fifo.sv
// Purpose: small byte fifo with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes: read data comes from a register
`timescale 1ns/100ps
`default_nettype none
module spov_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
)(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed
  {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [W-1:0] dout;
    logic dvalid;
  } spov_fifo_st_t;
  spov_fifo_st_t s_reg, s_next;
  logic [W-1:0] mem [D];
  logic push, pop, load;
  // storage written outside the state struct, memories do not pack well
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[s_reg.wp] <= in_data;
    end
  end
  assign in_ready = (s_reg.cnt != (AW+1)'(D));
  assign out_valid = s_reg.dvalid;
  assign out_data = s_reg.dout;
  assign push = in_valid && in_ready;
  // output register refills whenever it is empty or being taken
  assign load = (s_reg.cnt != '0) && (!s_reg.dvalid || out_ready);
  assign pop = load;
  // next state
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (load)
    begin
      s_next.dout = mem[s_reg.rp];
      s_next.rp = s_reg.rp + 1'b1;
      s_next.dvalid = 1'b1;
    end
    else if (out_ready)
    begin
      s_next.dvalid = 1'b0;
    end
    if (push && !pop)
    begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end
  // state register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule : spov_fifo
`default_nettype wire

// File: verilog/spov_port.sv
// Purpose: receive overflow flag and port enable of a synchronous serial port
// Assumes: shift logic outside delivers complete bytes as one-cycle strobes
// Notes: received bytes pass a 16-word fifo before the transfer buffer
// How it works
// - spi slave byte into full buffer sets overflow
// - overflowed byte is dropped, buffer kept
// - overflow only raised in spi slave or i2c receive role
// - master transfers start on buffer write only
// - i2c receive byte into full buffer sets overflow
// - flag cleared only by reset or by software writing zero
`include "spov_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module spov_port (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // configuration
  input wire logic port_enable_bit,
  input wire spov_pkg::spov_mode_t mode,
  input wire logic spi_master,
  input wire logic i2c_transmit,
  // overflow flag control: write strobe with data bit
  input wire logic flag_wr,
  input wire logic flag_wdata,
  output logic receive_overflow_flag,
  // shift register side
  input wire logic rx_done,
  input wire logic [`SPOV_BYTE_W-1:0] shift_register,
  output logic tx_start,
  output logic [`SPOV_BYTE_W-1:0] tx_data,
  // software buffer access
  input wire logic buf_wr,
  input wire logic [`SPOV_BYTE_W-1:0] buf_wdata,
  input wire logic buf_rd,
  output logic [`SPOV_BYTE_W-1:0] transfer_buffer,
  output logic buf_full,
  output logic rx_ready,
  // serial engine pins seen by the port
  output logic [2:0] eng_in,
  input wire logic [2:0] eng_out,
  input wire logic [2:0] eng_oe,
  // general-purpose pin drivers
  input wire spov_pkg::spov_gpio_t [2:0] gpio,
  output logic [2:0] gpio_in,
  // physical pins: 0 clock/scl, 1 data-out/sda, 2 data-in
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe
);
  import spov_pkg::*;
  // all state of the port except the pin synchroniser flops and the receive fifo lives in one struct:
  // ovf is the software-visible receive overflow flag
  // full marks unread data in the transfer buffer
  // buf_data is the transfer buffer as software reads it
  // start and txd hand a master transfer to the shift logic
  // pout and poe are the registered pad drivers
  // eng_in and gpio_in are the synchronised pad levels per owner
  // the pad side is registered so the mux never glitches the pins
  // when the enable changes in the middle of a cycle
  typedef struct packed
  {
    logic ovf;
    logic full;
    logic [`SPOV_BYTE_W-1:0] buf_data;
    logic start;
    logic [`SPOV_BYTE_W-1:0] txd;
    logic [2:0] pout;
    logic [2:0] poe;
    logic [2:0] eng_in;
    logic [2:0] gpio_in;
  } spov_st_t;
  spov_st_t s_reg, s_next;
  logic [2:0] sync1_reg, sync2_reg;
  logic f_valid, f_ready, q_valid, q_ready;
  logic [`SPOV_BYTE_W-1:0] q_data;
  logic overflow_ev;
  logic slave_rx;
  // a byte counts for overflow only in spi slave or i2c receive
  assign slave_rx = (mode == spov_mode_spi) ? !spi_master : !i2c_transmit;
  // overflow when a byte lands while the buffer still holds unread data
  assign overflow_ev = port_enable_bit && rx_done && slave_rx && s_reg.full;
  // incoming bytes only enter the fifo when they do not overflow
  assign f_valid = port_enable_bit && rx_done && !overflow_ev;
  // buffer takes a fifo word once software has read the previous one
  assign q_ready = !s_reg.full || buf_rd;
  // pads change with no relation to mclk, so two flops guard them
  // against metastability; the extra latency is two cycles, which
  // is far below any serial bit time this port can see
  // pin synchroniser, first stage read only by the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end
  // receive queue between the shift logic and the transfer buffer;
  // in master or i2c transmit roles bytes wait here without flagging,
  // and when it fills rx_ready drops so the shift logic must stall
  // limitation: overflow looks only at the buffer, not at this queue
  spov_fifo #(
    .W(`SPOV_BYTE_W),
    .D(`SPOV_FIFO_DEPTH),
    .AW(`SPOV_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(shift_register),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    // software read frees the buffer; full is what relies on
    if (buf_rd)
    begin
      s_next.full = 1'b0;
    end
    if (q_valid && q_ready)
    begin
      s_next.buf_data = q_data;
      s_next.full = 1'b1;
    end
    // master transfer only begins with a buffer write
    if (buf_wr && port_enable_bit && mode == spov_mode_spi && spi_master)
    begin
      s_next.start = 1'b1;
      s_next.txd = buf_wdata;
    end
    else if (buf_wr)
    begin
      s_next.txd = buf_wdata;
    end
    // clear by writing zero; a same-cycle event wins
    if (flag_wr && !flag_wdata)
    begin
      s_next.ovf = 1'b0;
    end
    else if (flag_wr && flag_wdata)
    begin
      s_next.ovf = 1'b1;
    end
    if (overflow_ev)
    begin
      s_next.ovf = 1'b1;
    end
    // pin mux: port owns pins when enabled, else gpio
    if (port_enable_bit)
    begin
      s_next.pout = eng_out;
      s_next.poe = (mode == spov_mode_i2c) ? (eng_oe & 3'h3) : eng_oe;
      s_next.eng_in = (mode == spov_mode_i2c) ? (sync2_reg & 3'h3) : sync2_reg;
      s_next.gpio_in = '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        s_next.pout[i] = gpio[i].out;
        s_next.poe[i] = gpio[i].oe;
      end
      s_next.eng_in = '0;
      s_next.gpio_in = sync2_reg;
    end
  end
  // state register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  // outputs
  // every data output comes straight from the state register,
  // only rx_ready is combinational as it is a handshake signal
  // flag and buffer as software sees them
  assign receive_overflow_flag = s_reg.ovf;
  assign transfer_buffer = s_reg.buf_data;
  assign buf_full = s_reg.full;
  // queue space towards the shift logic
  assign rx_ready = f_ready;
  // master transfer request, one cycle wide
  assign tx_start = s_reg.start;
  assign tx_data = s_reg.txd;
  // pad drivers and the two input views
  assign pin_out = s_reg.pout;
  assign pin_oe = s_reg.poe;
  assign eng_in = s_reg.eng_in;
  assign gpio_in = s_reg.gpio_in;
endmodule : spov_port
`default_nettype wire

// File: tb/spov_partner.sv
// Purpose: far-side serial master handing over finished bytes
// Assumes: one byte per request, one-cycle done pulse
// Notes: between bytes the data shows the inverted last byte
`timescale 1ns/100ps
`default_nettype none
module spov_partner (
  // clock and request
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] din,
  // shift side
  output logic rx_done,
  output logic [7:0] shift_register
);
  logic [7:0] last_reg;
  // byte complete for one cycle, then released
  always_ff @(posedge mclk)
  begin
    rx_done <= go;
    last_reg <= go ? din : last_reg;
  end
  // released lines must not look like the last byte
  assign shift_register = rx_done ? last_reg : ~last_reg;
endmodule : spov_partner
`default_nettype wire

// File: tb/spov_port_asserts.sv
// Purpose: checks on overflow flag, buffer and enable
// Assumes: one clock domain
// Notes: set beats clear, so clears are checked without a cause
`timescale 1ns/100ps
`default_nettype none
module spov_port_asserts (
  // clock, reset, configuration
  input wire logic mclk,
  input wire logic reset,
  input wire logic port_enable_bit,
  input wire spov_pkg::spov_mode_t mode,
  input wire logic spi_master,
  input wire logic i2c_transmit,
  // flag and buffer
  input wire logic flag_wr,
  input wire logic flag_wdata,
  input wire logic receive_overflow_flag,
  input wire logic rx_done,
  input wire logic buf_wr,
  input wire logic buf_rd,
  input wire logic [7:0] transfer_buffer,
  input wire logic buf_full,
  input wire logic tx_start
);
  import spov_pkg::*;
  // receiving role: spi slave or i2c receiver
  wire logic spi = mode == spov_mode_spi;
  wire logic rcv = spi ? !spi_master : !i2c_transmit;
  wire logic cause = rx_done && rcv && port_enable_bit || flag_wr && flag_wdata;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_ovf_set: assert property (
    port_enable_bit && rcv && rx_done && buf_full |=> receive_overflow_flag) else $error("no set");
  a_ovf_cause: assert property (
    $rose(receive_overflow_flag) |-> $past(cause)) else $error("flag without cause");
  a_ovf_hold: assert property (
    receive_overflow_flag && !flag_wr |=> receive_overflow_flag) else $error("flag lost");
  a_ovf_clear: assert property (
    flag_wr && !flag_wdata && !cause |=> !receive_overflow_flag) else $error("no clear");
  a_buf_kept: assert property (
    buf_full && !buf_rd && !buf_wr |=> buf_full && $stable(transfer_buffer)) else $error("buf");
  a_buf_read: assert property (
    buf_full && buf_rd && !buf_wr |=> !buf_full || $changed(transfer_buffer))
    else $error("full after read");
  a_tx_start: assert property (
    port_enable_bit && buf_wr && spi_master && spi |=> tx_start) else $error("no tx");
  a_off_quiet: assert property (
    !port_enable_bit && !flag_wr && !receive_overflow_flag |=> !receive_overflow_flag)
    else $error("flag while off");
  c_ovf: cover property (rcv && rx_done && buf_full);
  c_tx: cover property (tx_start);
  c_clr: cover property (flag_wr && receive_overflow_flag);
endmodule : spov_port_asserts
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: directed bench for the overflow flag and enable block
// Assumes: each role starts from a fresh reset
// Notes: fresh resets keep queued bytes from leaking between roles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import spov_pkg::*;
  logic mclk = 0, reset = 1, en = 1, sm = 0, it = 0, fw = 0, go = 0, bw = 0, br = 0;
  logic rxd, ovf, full, txs, rr;
  logic [2:0] po, gi;
  logic [7:0] din = 8'h00, sr, tb, txd;
  logic [2:0] eo = 3'h0, eng_in, pin_oe, pin_in = 3'h0;
  spov_mode_t md = spov_mode_spi;
  spov_gpio_t [2:0] gp = '0;
  int bad_count = 0, checked = 0;
  always #5 mclk = ~mclk;
  spov_partner i_far (.mclk(mclk), .go(go), .din(din), .rx_done(rxd), .shift_register(sr));
  spov_port i_dut (.mclk(mclk), .reset(reset), .port_enable_bit(en), .mode(md),
    .spi_master(sm), .i2c_transmit(it), .flag_wr(fw), .flag_wdata(1'b0),
    .receive_overflow_flag(ovf), .rx_done(rxd), .shift_register(sr), .tx_start(txs),
    .tx_data(txd), .buf_wr(bw), .buf_wdata(8'h5a), .buf_rd(br), .transfer_buffer(tb),
    .buf_full(full), .rx_ready(rr), .eng_in(eng_in), .eng_out(3'h2), .eng_oe(eo),
    .gpio(gp), .gpio_in(gi), .pin_in(pin_in), .pin_out(po), .pin_oe(pin_oe));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // one byte from the far side
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    go <= 1;
    din <= b;
    @(posedge mclk);
    go <= 0;
  endtask : send
  task automatic wait_full;
    for (int n = 0; n < 20; n++)
    begin
      @(negedge mclk);
      if (full === 1'b1)
        return;
    end
    bad_count++;
    give_verdict;
  endtask : wait_full
  initial
  begin
    // roles: spi slave, spi master, i2c receive, i2c transmit
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      reset <= 1;
      md <= i[1] ? spov_mode_i2c : spov_mode_spi;
      sm <= i == 1;
      it <= i == 3;
      repeat (5) @(posedge mclk);
      reset <= 0;
      send(8'h3c);
      wait_full;
      send(8'hc3);
      repeat (8) @(negedge mclk);
      chk("flag", ovf, i % 2 == 0);
      chk("buffer", tb, 8'h3c);
      @(posedge mclk);
      fw <= 1;
      @(posedge mclk);
      fw <= 0;
      br <= 1;
      @(posedge mclk);
      br <= 0;
      @(negedge mclk);
      chk("flag and full", {ovf, full}, 8'(i % 2));
    end
    // master write starts a transfer
    @(posedge mclk);
    md <= spov_mode_spi;
    sm <= 1;
    bw <= 1;
    @(posedge mclk);
    bw <= 0;
    @(negedge mclk);
    chk("tx start", txs, 1);
    chk("tx data", txd, 8'h5a);
    // disabled: gpio owns the pins
    @(posedge mclk);
    en <= 0;
    gp <= 6'h33;
    pin_in <= 3'h6;
    send(8'h77);
    repeat (4) @(negedge mclk);
    chk("gpio oe", pin_oe, 3'h5);
    chk("gpio out", po, 3'h5);
    chk("gpio in", gi, 3'h6);
    @(posedge mclk);
    en <= 1;
    eo <= 3'h3;
    repeat (4) @(negedge mclk);
    chk("port oe", pin_oe, 3'h3);
    chk("port in", eng_in, 3'h6);
    chk("port out", po, 3'h2);
    chk("gpio in off", gi, 3'h0);
    chk("rx ready", rr, 8'h01);
    give_verdict;
  end
endmodule : tb_top
bind spov_port spov_port_asserts i_chk (.mclk(mclk), .reset(reset),
  .port_enable_bit(port_enable_bit), .mode(mode), .spi_master(spi_master),
  .i2c_transmit(i2c_transmit), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
  .receive_overflow_flag(receive_overflow_flag), .rx_done(rx_done), .buf_wr(buf_wr),
  .buf_rd(buf_rd), .transfer_buffer(transfer_buffer), .buf_full(buf_full),
  .tx_start(tx_start));
`default_nettype wire
